// ===== design/autoneg_partner_status_regs.sv
`timescale 1ns/1ns
// How it works
// R1 - partner base-page abilities readable at index 0x05, all zero after reset.
// R2 - with next pages supported, a next page overwrites the word after completion.
// R3 - bit 15 shows the partner asking for next page exchange.
// R4 - bit 14 follows the negotiation engine acknowledge level.
// R5 - bit 13 shows the partner remote fault.
// R6 - bit 12 reserved, reads zero; software writes zero.
// R7 - bit 11 partner asymmetric pause, bit 10 symmetric pause.
// R8 - bits 9 to 5: T4, TX full, TX, 10T full, 10T.
// R9 - bits 4:0 partner selector code, zero after reset.
// R10 - selector 00001 means IEEE 802.3, our own advertised value.
// R11 - expansion register at index 0x06, bits 15:5 read zero.
// R12 - expansion bit 4 shows parallel detection fault.
// R13 - expansion bit 3 shows partner next page ability.
// R14 - expansion bit 2 is a constant one.
// R15 - expansion bit 1 sets on page received, clears when read.
// R16 - expansion bit 0 shows partner negotiation ability.
// R17 - writes to either status register change nothing.
module autoneg_partner_status_regs #(
	parameter bit NEXT_PAGE_SUPPORTED = 1'b1
) (
	input  wire logic                          i_core_clk,      // core clock
	input  wire logic                          i_reset_n,       // async reset, active low
	input  wire autoneg_partner_pkg::nego_in_t i_nego,          // negotiation engine results
	input  wire autoneg_partner_pkg::axi_req_t i_axi,           // axi4-lite requests
	output autoneg_partner_pkg::axi_rsp_t      o_axi,           // axi4-lite responses
	output logic                               o_irq,           // level interrupt
	output logic                               o_partner_ieee   // partner selector is 802.3
);

	typedef struct packed {
		autoneg_partner_pkg::wr_state_t            wr_state;
		autoneg_partner_pkg::rd_state_t            rd_state;
		logic                                      aw_got;
		logic                                      w_got;
		logic [7:0]                                aw_idx;
		logic [31:0]                               wdata;
		logic [3:0]                                wstrb;
		autoneg_partner_pkg::axi_rsp_t             rsp;
		autoneg_partner_pkg::ability_t             ability;
		logic                                      pd_fault;
		logic                                      partner_np;
		logic                                      page_rx;
		logic                                      partner_an;
		logic                                      ack_seen;
		logic [autoneg_partner_pkg::EVT_W-1:0]     irq_mask;
		logic                                      irq;
		logic                                      partner_ieee;
	} state_t;

	state_t                                q;
	state_t                                d;
	logic [autoneg_partner_pkg::EVT_W-1:0] evt_set;
	logic [autoneg_partner_pkg::EVT_W-1:0] evt_clr;
	logic [autoneg_partner_pkg::EVT_W-1:0] evt_flags;
	logic                                  aw_take;
	logic                                  w_take;
	logic                                  ar_take;
	logic [7:0]                            ar_idx;
	logic [15:0]                           exp_word;

	event_sticky_bank #(
		.W (autoneg_partner_pkg::EVT_W)
	) u_events (
		.i_core_clk (i_core_clk),
		.i_reset_n  (i_reset_n),
		.i_set      (evt_set),
		.i_clr      (evt_clr),
		.o_flags    (evt_flags)
	);

	// turns a captured link code word into the ability layout
	function automatic autoneg_partner_pkg::ability_t to_ability(input logic [15:0] word);
		autoneg_partner_pkg::ability_t a;
		a = autoneg_partner_pkg::ability_t'(word);
		a.reserved_bit = 1'b0; // R6
		return a;
	endfunction

	always_comb begin
		d        = q;
		evt_set  = '0;
		evt_clr  = '0;
		exp_word = '0; // R11
		ar_idx   = i_axi.araddr[autoneg_partner_pkg::ADDR_W-1:2];
		aw_take  = i_axi.awvalid && q.rsp.awready;
		w_take   = i_axi.wvalid && q.rsp.wready;
		ar_take  = i_axi.arvalid && q.rsp.arready;

		// captured partner word; base page first, next page may replace it
		if (i_nego.base_page_valid) begin
			d.ability = to_ability(i_nego.base_page_word); // R1 R3 R5 R7 R8 R9
		end
		if (NEXT_PAGE_SUPPORTED && i_nego.nego_complete && i_nego.next_page_valid) begin
			d.ability = to_ability(i_nego.next_page_word); // R2
		end
		// acknowledge is owned by the engine, not by the captured word
		d.ability.partner_ack = i_nego.partner_ack; // R4
		d.partner_ieee = (d.ability.selector == autoneg_partner_pkg::SELECTOR_IEEE_8023); // R10

		d.pd_fault   = i_nego.parallel_detect_fault; // R12
		d.partner_np = i_nego.partner_nextpage_capable; // R13
		d.partner_an = i_nego.partner_negotiation_capable; // R16
		d.ack_seen   = i_nego.partner_ack;

		evt_set[autoneg_partner_pkg::EVT_PAGE_RX]     = i_nego.page_received;
		evt_set[autoneg_partner_pkg::EVT_PD_FAULT]    = i_nego.parallel_detect_fault && !q.pd_fault;
		evt_set[autoneg_partner_pkg::EVT_PARTNER_ACK] = i_nego.partner_ack && !q.ack_seen;

		exp_word[autoneg_partner_pkg::EXP_PD_FAULT_BIT]    = q.pd_fault; // R12
		exp_word[autoneg_partner_pkg::EXP_PARTNER_NP_BIT]  = q.partner_np; // R13
		exp_word[autoneg_partner_pkg::EXP_LOCAL_NP_BIT]    = 1'b1; // R14
		exp_word[autoneg_partner_pkg::EXP_PAGE_RX_BIT]     = q.page_rx; // R15
		exp_word[autoneg_partner_pkg::EXP_PARTNER_NEG_BIT] = q.partner_an; // R16

		// write channel: address and data taken in either order
		if (aw_take) begin
			d.aw_got = 1'b1;
			d.aw_idx = i_axi.awaddr[autoneg_partner_pkg::ADDR_W-1:2];
		end
		if (w_take) begin
			d.w_got = 1'b1;
			d.wdata = i_axi.wdata;
			d.wstrb = i_axi.wstrb;
		end
		case (q.wr_state)
			autoneg_partner_pkg::WR_COLLECT: begin
				if (d.aw_got && d.w_got) begin
					d.aw_got         = 1'b0;
					d.w_got          = 1'b0;
					d.rsp.bvalid     = 1'b1;
					d.rsp.bresp      = autoneg_partner_pkg::RESP_OKAY;
					d.wr_state       = autoneg_partner_pkg::WR_RESP;
					case (d.aw_idx)
						autoneg_partner_pkg::IDX_PARTNER_ABILITY,
						autoneg_partner_pkg::IDX_NEGO_EXPANSION: begin
							// accepted but dropped: contents belong to hardware
							d.rsp.bresp = autoneg_partner_pkg::RESP_OKAY; // R17
						end
						autoneg_partner_pkg::IDX_IRQ_STATUS: begin
							if (d.wstrb[0]) begin
								evt_clr = d.wdata[autoneg_partner_pkg::EVT_W-1:0];
							end
						end
						autoneg_partner_pkg::IDX_IRQ_MASK: begin
							if (d.wstrb[0]) begin
								d.irq_mask = d.wdata[autoneg_partner_pkg::EVT_W-1:0];
							end
						end
						default: begin
							d.rsp.bresp = autoneg_partner_pkg::RESP_SLVERR;
						end
					endcase
				end
			end
			autoneg_partner_pkg::WR_RESP: begin
				if (i_axi.bready) begin
					d.rsp.bvalid = 1'b0;
					d.wr_state   = autoneg_partner_pkg::WR_COLLECT;
				end
			end
			default: begin
				d.rsp.bvalid = 1'b0;
				d.aw_got     = 1'b0;
				d.w_got      = 1'b0;
				d.wr_state   = autoneg_partner_pkg::WR_COLLECT;
			end
		endcase
		d.rsp.awready = (d.wr_state == autoneg_partner_pkg::WR_COLLECT) && !d.aw_got;
		d.rsp.wready  = (d.wr_state == autoneg_partner_pkg::WR_COLLECT) && !d.w_got;

		// read channel; data is the value before any read side effect
		case (q.rd_state)
			autoneg_partner_pkg::RD_IDLE: begin
				if (ar_take) begin
					d.rsp.rvalid = 1'b1;
					d.rsp.rresp  = autoneg_partner_pkg::RESP_OKAY;
					d.rsp.rdata  = '0;
					d.rd_state   = autoneg_partner_pkg::RD_DATA;
					case (ar_idx)
						autoneg_partner_pkg::IDX_PARTNER_ABILITY: begin
							d.rsp.rdata[15:0] = q.ability; // R1
						end
						autoneg_partner_pkg::IDX_NEGO_EXPANSION: begin
							d.rsp.rdata[15:0] = exp_word; // R11
							d.page_rx         = 1'b0; // R15
						end
						autoneg_partner_pkg::IDX_IRQ_STATUS: begin
							d.rsp.rdata[autoneg_partner_pkg::EVT_W-1:0] = evt_flags;
						end
						autoneg_partner_pkg::IDX_IRQ_MASK: begin
							d.rsp.rdata[autoneg_partner_pkg::EVT_W-1:0] = q.irq_mask;
						end
						default: begin
							d.rsp.rresp = autoneg_partner_pkg::RESP_SLVERR;
						end
					endcase
				end
			end
			autoneg_partner_pkg::RD_DATA: begin
				if (i_axi.rready) begin
					d.rsp.rvalid = 1'b0;
					d.rd_state   = autoneg_partner_pkg::RD_IDLE;
				end
			end
			default: begin
				d.rsp.rvalid = 1'b0;
				d.rd_state   = autoneg_partner_pkg::RD_IDLE;
			end
		endcase
		d.rsp.arready = (d.rd_state == autoneg_partner_pkg::RD_IDLE);

		// a page arriving in the clearing read cycle survives
		if (i_nego.page_received) begin
			d.page_rx = 1'b1; // R15
		end

		d.irq = |(evt_flags & q.irq_mask);
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q.wr_state     <= autoneg_partner_pkg::WR_COLLECT;
			q.rd_state     <= autoneg_partner_pkg::RD_IDLE;
			q.aw_got       <= 1'b0;
			q.w_got        <= 1'b0;
			q.aw_idx       <= 8'h00;
			q.wdata        <= 32'h0000_0000;
			q.wstrb        <= 4'h0;
			q.rsp          <= '0;
			q.ability      <= autoneg_partner_pkg::ABILITY_RESET; // R1 R9
			q.pd_fault     <= 1'b0;
			q.partner_np   <= 1'b0;
			q.page_rx      <= 1'b0;
			q.partner_an   <= 1'b0;
			q.ack_seen     <= 1'b0;
			q.irq_mask     <= autoneg_partner_pkg::IRQ_MASK_RESET;
			q.irq          <= 1'b0;
			q.partner_ieee <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign o_axi          = q.rsp;
	assign o_irq          = q.irq;
	assign o_partner_ieee = q.partner_ieee;

endmodule // autoneg_partner_status_regs

// ===== design/autoneg_partner_pkg.sv
package autoneg_partner_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_PARTNER_ABILITY   = 8'h05;
	localparam logic [7:0] IDX_NEGO_EXPANSION    = 8'h06;
	localparam logic [7:0] IDX_IRQ_STATUS        = 8'h10;
	localparam logic [7:0] IDX_IRQ_MASK          = 8'h11;

	localparam int         ADDR_W                = 10;
	localparam int         EVT_W                 = 3;

	// interrupt event bit positions
	localparam int         EVT_PAGE_RX           = 0;
	localparam int         EVT_PD_FAULT          = 1;
	localparam int         EVT_PARTNER_ACK       = 2;

	// expansion register bit positions
	localparam int         EXP_PARTNER_NEG_BIT   = 0;
	localparam int         EXP_PAGE_RX_BIT       = 1;
	localparam int         EXP_LOCAL_NP_BIT      = 2;
	localparam int         EXP_PARTNER_NP_BIT    = 3;
	localparam int         EXP_PD_FAULT_BIT      = 4;

	localparam logic [4:0] SELECTOR_IEEE_8023    = 5'h01;
	localparam logic [4:0] SELECTOR_RESET        = 5'h00;
	localparam logic [15:0] ABILITY_RESET        = 16'h0000;
	localparam logic [EVT_W-1:0] IRQ_MASK_RESET  = 3'h0;

	localparam logic [1:0] RESP_OKAY             = 2'h0;
	localparam logic [1:0] RESP_SLVERR           = 2'h2;

	typedef struct packed {
		logic       partner_next_page_request;
		logic       partner_ack;
		logic       remote_fault_flag;
		logic       reserved_bit;
		logic       asym_pause_cap;
		logic       sym_pause_cap;
		logic       cap_hundred_t4;
		logic       cap_hundred_tx_full;
		logic       cap_hundred_tx;
		logic       cap_ten_t_full;
		logic       cap_ten_t;
		logic [4:0] selector;
	} ability_t;

	typedef struct packed {
		logic        base_page_valid;
		logic [15:0] base_page_word;
		logic        next_page_valid;
		logic [15:0] next_page_word;
		logic        nego_complete;
		logic        partner_ack;
		logic        page_received;
		logic        parallel_detect_fault;
		logic        partner_nextpage_capable;
		logic        partner_negotiation_capable;
	} nego_in_t;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_t;

	typedef enum logic [1:0] {
		WR_COLLECT = 2'h0,
		WR_RESP    = 2'h1
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'h0,
		RD_DATA = 2'h1
	} rd_state_t;

endpackage

// ===== design/event_sticky_bank.sv
`timescale 1ns/1ns
module event_sticky_bank #(
	parameter int W = 3
) (
	input  wire logic         i_core_clk, // core clock
	input  wire logic         i_reset_n,  // async reset, active low
	input  wire logic [W-1:0] i_set,      // event pulses
	input  wire logic [W-1:0] i_clr,      // write-one-to-clear pulses
	output logic      [W-1:0] o_flags     // sticky flags
);

	typedef struct packed {
		logic [W-1:0] flags;
	} sticky_state_t;

	sticky_state_t q;
	sticky_state_t d;

	// set wins so an event in the clearing cycle is kept
	always_comb begin
		d = q;
		d.flags = (q.flags & ~i_clr) | i_set;
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_flags = q.flags;

endmodule // event_sticky_bank

// ===== dv/autoneg_status_checker.sv
`timescale 1ns/1ns
module autoneg_status_checker (
	input wire logic                          i_core_clk,    // clock
	input wire logic                          i_reset_n,     // reset, active low
	input wire autoneg_partner_pkg::nego_in_t i_nego,        // engine results
	input wire autoneg_partner_pkg::axi_req_t i_axi,         // requests
	input wire autoneg_partner_pkg::axi_rsp_t o_axi,         // responses
	input wire logic                          o_irq,         // interrupt
	input wire logic                          o_partner_ieee // selector flag
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	logic [7:0] ix;
	logic       ar_t;
	logic       map;
	assign ix = i_axi.araddr[9:2];
	assign ar_t = i_axi.arvalid && o_axi.arready;
	assign map = ix inside {8'h05, 8'h06, 8'h10, 8'h11};
	bresp_hold_a: assert property (o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid && $stable(o_axi.bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata))
		else $error("read data dropped early");
	wr_answer_a: assert property (i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready |=> o_axi.bvalid)
		else $error("write response late");
	rd_answer_a: assert property (ar_t |=> o_axi.rvalid) else $error("read data late");
	ready_block_a: assert property (o_axi.bvalid |-> !o_axi.awready && !o_axi.wready && 1'b1)
		else $error("write ready during response");
	exp_fixed_a: assert property (ar_t && ix == 8'h06 |=> o_axi.rdata[31:5] == 27'h0 && o_axi.rdata[2])
		else $error("expansion fixed bits wrong");
	ability_resv_a: assert property (ar_t && ix == 8'h05 |=> o_axi.rdata[31:16] == 16'h0 && !o_axi.rdata[12])
		else $error("ability reserved bits wrong");
	exp_levels_a: assert property (ar_t && ix == 8'h06
		&& $stable({i_nego.parallel_detect_fault, i_nego.partner_nextpage_capable, i_nego.partner_negotiation_capable})
		|=> {o_axi.rdata[4], o_axi.rdata[3], o_axi.rdata[0]} == $past({i_nego.parallel_detect_fault,
		i_nego.partner_nextpage_capable, i_nego.partner_negotiation_capable})) else $error("expansion levels wrong");
	unmapped_rd_a: assert property (ar_t && !map |=> o_axi.rresp == 2'h2 && o_axi.rdata == 32'h0)
		else $error("unmapped read not refused");
	mapped_rd_a: assert property (ar_t && map |=> o_axi.rresp == 2'h0) else $error("mapped read refused");
endmodule // autoneg_status_checker

bind autoneg_partner_status_regs autoneg_status_checker autoneg_status_checker_i (.i_core_clk(i_core_clk),
	.i_reset_n(i_reset_n), .i_nego(i_nego), .i_axi(i_axi), .o_axi(o_axi), .o_irq(o_irq),
	.o_partner_ieee(o_partner_ieee));

// ===== dv/link_partner_model.sv
`timescale 1ns/1ns
module link_partner_model (
	input wire logic                     i_core_clk, // clock
	output autoneg_partner_pkg::nego_in_t o_nego     // engine results
);
	initial o_nego = '0;
	task automatic page(input logic nxt, input logic [15:0] w);
		@(posedge i_core_clk);
		o_nego.base_page_valid <= !nxt;
		o_nego.next_page_valid <= nxt;
		o_nego.base_page_word <= w;
		o_nego.next_page_word <= w;
		o_nego.page_received <= 1'b1;
		@(posedge i_core_clk);
		o_nego.base_page_valid <= 1'b0;
		o_nego.next_page_valid <= 1'b0;
		o_nego.page_received <= 1'b0;
		// stale words are inverted so a late capture shows up
		o_nego.base_page_word <= ~w;
		o_nego.next_page_word <= ~w;
	endtask
	// order: complete, fault, np capable, an capable, ack
	task automatic levels(input logic [4:0] v);
		@(posedge i_core_clk);
		{o_nego.nego_complete, o_nego.parallel_detect_fault, o_nego.partner_nextpage_capable,
			o_nego.partner_negotiation_capable, o_nego.partner_ack} <= v;
	endtask
endmodule // link_partner_model

// ===== dv/testbench.sv
`timescale 1ns/1ns
module testbench;
	localparam logic [9:0] A_AB = {autoneg_partner_pkg::IDX_PARTNER_ABILITY, 2'h0};
	localparam logic [9:0] A_EX = {autoneg_partner_pkg::IDX_NEGO_EXPANSION, 2'h0};
	localparam logic [9:0] A_ST = {autoneg_partner_pkg::IDX_IRQ_STATUS, 2'h0};
	localparam logic [9:0] A_MK = {autoneg_partner_pkg::IDX_IRQ_MASK, 2'h0};
	logic                          i_core_clk = 1'b0;
	logic                          i_reset_n = 1'b0;
	autoneg_partner_pkg::axi_req_t req = '0;
	autoneg_partner_pkg::axi_rsp_t rsp;
	autoneg_partner_pkg::nego_in_t nego;
	logic                          irq;
	logic                          ieee;
	logic [31:0]                   d;
	logic [1:0]                    r;
	int                            n_mismatch = 0;
	int                            comparisons = 0;
	always #50 i_core_clk = ~i_core_clk;
	link_partner_model link_partner_model_i (.i_core_clk(i_core_clk), .o_nego(nego));
	autoneg_partner_status_regs autoneg_partner_status_regs_i (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
		.i_nego(nego), .i_axi(req), .o_axi(rsp), .o_irq(irq), .o_partner_ieee(ieee));
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] v);
		logic pa;
		logic pw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge i_core_clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= v;
		req.wstrb <= 4'hf;
		// either channel may be taken first; each drops after its own edge
		while (pa || pw) begin
			@(negedge i_core_clk);
			pa = pa && !rsp.awready;
			pw = pw && !rsp.wready;
			@(posedge i_core_clk);
			req.awvalid <= pa;
			req.wvalid <= pw;
		end
		// late bready lets the response wait a cycle
		@(posedge i_core_clk);
		req.bready <= 1'b1;
		do @(negedge i_core_clk); while (rsp.bvalid !== 1'b1);
		r = rsp.bresp;
		@(posedge i_core_clk);
		req.bready <= 1'b0;
	endtask
	task automatic rdchk(input string s, input logic [9:0] a, input logic [31:0] e);
		@(posedge i_core_clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		do @(negedge i_core_clk); while (rsp.arready !== 1'b1);
		@(posedge i_core_clk);
		req.arvalid <= 1'b0;
		@(posedge i_core_clk);
		req.rready <= 1'b1;
		do @(negedge i_core_clk); while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
		@(posedge i_core_clk);
		req.rready <= 1'b0;
		chk(s, e, d);
	endtask
	task automatic t_reset();
		rdchk("ability", A_AB, 32'h0);
		rdchk("expansion", A_EX, 32'h4);
		rdchk("mask", A_MK, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		$display("test reset done");
	endtask
	task automatic t_ability();
		logic [15:0] w;
		for (int i = 0; i < 16; i++) begin
			w = 16'h1 << i;
			link_partner_model_i.page(1'b0, w);
			rdchk("ability", A_AB, {16'h0, w & 16'hafff});
			chk("ieee", {31'h0, w[4:0] == autoneg_partner_pkg::SELECTOR_IEEE_8023}, {31'h0, ieee});
		end
		$display("test ability done");
	endtask
	task automatic t_expansion();
		link_partner_model_i.page(1'b1, 16'h0400);
		rdchk("ability", A_AB, 32'h8000);
		link_partner_model_i.levels(5'h1f);
		link_partner_model_i.page(1'b1, 16'h8001);
		rdchk("ability", A_AB, 32'hc001);
		rdchk("expansion", A_EX, 32'h1f);
		rdchk("expansion", A_EX, 32'h1d);
		$display("test expansion done");
	endtask
	task automatic t_irq();
		rdchk("status", A_ST, 32'h7);
		chk("irq", 32'h0, {31'h0, irq});
		wr(A_MK, 32'h7);
		repeat (2) @(negedge i_core_clk);
		chk("irq", 32'h1, {31'h0, irq});
		wr(A_ST, 32'h7);
		rdchk("status", A_ST, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		$display("test irq done");
	endtask
	task automatic t_writes();
		wr(A_AB, 32'hffff);
		chk("bresp", 32'h0, {30'h0, r});
		wr(A_EX, 32'hffff);
		chk("bresp", 32'h0, {30'h0, r});
		rdchk("ability", A_AB, 32'hc001);
		rdchk("expansion", A_EX, 32'h1d);
		wr(10'h3fc, 32'h1);
		chk("bresp", 32'h2, {30'h0, r});
		rdchk("unmapped", 10'h3fc, 32'h0);
		chk("rresp", 32'h2, {30'h0, r});
		$display("test writes done");
	endtask
	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		t_reset();
		t_ability();
		t_expansion();
		t_irq();
		t_writes();
		finish_test();
	end
	// about a hundred times the expected run
	initial begin
		#2000000;
		n_mismatch++;
		finish_test();
	end
endmodule // testbench
